// ---- rtl/ucev_top.sv ----
// Uncore event counters: six paired qualification/counter registers,
// a latency control register and a 64-bit latency accumulator, reached
// by model register reads and writes and by the counter-read port.
// Both ports answer exactly one cycle after a request and never stall;
// an unmapped address or an out-of-range index returns a fault and zero.
// The counter-read port sees only the low words; its upper result is zero.
// Assumes event sources deliver one-cycle qualified strobes, already
// filtered with the qualification fields this block drives out.
//
// Functional notes
// - Lower halves of the six event registers count 32-bit.
// - Counter-read indices 18 to 25 select registers.
// - Counter-read upper result is always zero.
// - Four classes: bus queue, snoop, ready, latency.
// - Two bus queue registers, qualifier over counter.
// - Bus queue counter idle until qualifier non-zero.
// - Two snoop queue registers, same split.
// - Snoop counter starts after non-zero qualifier write.
// - Two data-ready registers, qualifier over counter.
// - Data-ready counter starts after non-zero qualifier.
// - Latency sums weighted cycles of queued transactions.
// - Latency enable bit 26 turns accumulation on.
// - Clearing bit 26 freezes the latency sum.
// - Latency counter is a full 64-bit register.
`timescale 1ns/1ps
module ucev_top #(
    parameter int WEIGHT_W = ucev_pkg::LATENCY_WEIGHT_W
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_msr_wr,
    input wire logic i_msr_rd,
    input wire logic [31:0] i_msr_addr,
    input wire logic [63:0] i_msr_wdata,
    output logic [63:0] o_msr_rdata,
    output logic o_msr_ack,
    output logic o_msr_fault,
    input wire logic i_pmc_rd,
    input wire logic [31:0] i_pmc_index,
    output logic [31:0] o_pmc_lower,
    output logic [31:0] o_pmc_upper_result,
    output logic o_pmc_ack,
    output logic o_pmc_fault,
    input wire logic [1:0] i_inner_bus_request_queue_hit,
    input wire logic [1:0] i_inner_snoop_queue_hit,
    input wire logic [1:0] i_external_bus_data_ready_hit,
    input wire logic [WEIGHT_W-1:0] i_latency_weight,
    output logic [191:0] o_event_qual,
    output logic [5:0] o_event_active,
    output logic [63:0] o_latency_control,
    output logic o_latency_active
);

    // Decoded register index of an address, with a hit flag
    // Bit 3 flags a hit; bits 2:0 number the registers in address order
    function automatic logic [3:0] decode_addr(input logic [31:0] addr);
        logic [3:0] res;
        res = 4'h0;
        unique case (addr)
            ucev_pkg::BUS_QUEUE_EVENT_0_OFS: res = 4'h8;
            ucev_pkg::BUS_QUEUE_EVENT_1_OFS: res = 4'h9;
            ucev_pkg::SNOOP_QUEUE_EVENT_0_OFS: res = 4'ha;
            ucev_pkg::SNOOP_QUEUE_EVENT_1_OFS: res = 4'hb;
            ucev_pkg::BUS_DATA_READY_EVENT_0_OFS: res = 4'hc;
            ucev_pkg::BUS_DATA_READY_EVENT_1_OFS: res = 4'hd;
            ucev_pkg::LATENCY_CONTROL_OFS: res = 4'he;
            ucev_pkg::LATENCY_COUNTER_OFS: res = 4'hf;
            default: res = 4'h0;
        endcase
        return res;
    endfunction

    // Address decode for the model register port
    logic [3:0] wr_dec;
    logic [3:0] rd_dec;
    logic wr_hit;
    logic rd_hit;
    logic [2:0] wr_idx;
    logic [2:0] rd_idx;
    logic [7:0] wr_sel;

    assign wr_dec = decode_addr(i_msr_addr);
    assign rd_dec = wr_dec;
    assign wr_hit = i_msr_wr && wr_dec[3];
    assign rd_hit = i_msr_rd && rd_dec[3];
    assign wr_idx = wr_dec[2:0];
    assign rd_idx = rd_dec[2:0];

    // One write select per register; full 64-bit writes only
    always_comb
    begin
        wr_sel = 8'h00;
        if (wr_hit)
        begin
            wr_sel[wr_idx] = 1'b1;
        end
    end

    // Event strobes gathered in address order
    // Strobes arrive pre-qualified by the sources from o_event_qual
    logic [5:0] event_hit;

    assign event_hit = {i_external_bus_data_ready_hit, i_inner_snoop_queue_hit, i_inner_bus_request_queue_hit};

    // Per-register qualification halves and counter halves
    logic [31:0] qual_r [0:5];
    logic [31:0] qual_nxt [0:5];
    logic [5:0] active_r;
    logic [5:0] active_nxt;
    logic [31:0] count_q [0:5];

    genvar g;
    generate
        for (g = 0; g < ucev_pkg::NUM_EVENT_REGS; g++)
        begin : g_event
            // Upper half holds qualification and enable control
            always_comb
            begin
                qual_nxt[g] = qual_r[g];
                if (wr_sel[g])
                begin
                    qual_nxt[g] = i_msr_wdata[ucev_pkg::QUAL_MSB:ucev_pkg::QUAL_LSB];
                end
            end

            // Counting runs while any qualification bit is set
            always_comb
            begin
                active_nxt[g] = |qual_nxt[g];
            end

            // Qualification and activity registers
            always_ff @(posedge i_clk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                begin
                    qual_r[g] <= ucev_pkg::QUAL_RESET;
                    active_r[g] <= 1'b0;
                end
                else
                begin
                    qual_r[g] <= qual_nxt[g];
                    active_r[g] <= active_nxt[g];
                end
            end

            // A software write in the same cycle as a strobe wins; that strobe is dropped
            // Lower half is a 32-bit counter stepping once per strobe
            ucev_count32 #(
                .W(ucev_pkg::HALF_W)
            ) u_count (
                .i_clk(i_clk),
                .i_arst_n(i_arst_n),
                .i_load(wr_sel[g]),
                .i_load_value(i_msr_wdata[ucev_pkg::COUNT_MSB:ucev_pkg::COUNT_LSB]),
                .i_step(active_r[g] && event_hit[g]),
                .o_count(count_q[g])
            );

            assign o_event_qual[g*32 +: 32] = qual_r[g];
        end
    endgenerate

    assign o_event_active = active_r;

    // Latency control register; only the enable bit steers logic
    // The other bits are kept so software reads back what it wrote
    logic [63:0] lat_ctl_r;
    logic [63:0] lat_ctl_nxt;
    logic lat_en_r;
    logic lat_en_nxt;

    always_comb
    begin
        lat_ctl_nxt = lat_ctl_r;
        if (wr_sel[ucev_pkg::LATENCY_CTL_IDX])
        begin
            lat_ctl_nxt = i_msr_wdata;
        end
        lat_en_nxt = lat_ctl_nxt[ucev_pkg::LATENCY_EN_BIT];
    end

    // Latency control and enable registers
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            lat_ctl_r <= ucev_pkg::LATENCY_CTL_RESET;
            lat_en_r <= 1'b0;
        end
        else
        begin
            lat_ctl_r <= lat_ctl_nxt;
            lat_en_r <= lat_en_nxt;
        end
    end

    assign o_latency_control = lat_ctl_r;
    assign o_latency_active = lat_en_r;

    // Weighted latency sum, frozen while enable is clear
    logic [63:0] lat_cnt_q;

    ucev_latency_acc #(
        .CW(ucev_pkg::REG_W),
        .WW(WEIGHT_W)
    ) u_latency (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_load(wr_sel[ucev_pkg::LATENCY_CNT_IDX]),
        .i_load_value(i_msr_wdata),
        .i_enable(lat_en_r),
        .i_weight(i_latency_weight),
        .o_count(lat_cnt_q)
    );

    // Read data of every register in address order
    logic [63:0] reg_view [0:7];

    always_comb
    begin
        for (int k = 0; k < ucev_pkg::NUM_EVENT_REGS; k++)
        begin
            reg_view[k] = {qual_r[k], count_q[k]};
        end
        reg_view[ucev_pkg::LATENCY_CTL_IDX] = lat_ctl_r;
        reg_view[ucev_pkg::LATENCY_CNT_IDX] = lat_cnt_q;
    end

    // Read data of a mapped register; zero on a miss or a write
    logic [63:0] msr_view;

    always_comb
    begin
        msr_view = 64'h0000000000000000;
        if (rd_hit)
        begin
            msr_view = reg_view[rd_idx];
        end
    end

    // Model register read answer, one cycle after the request
    logic [63:0] msr_rdata_r;
    logic [63:0] msr_rdata_nxt;
    logic msr_ack_r;
    logic msr_ack_nxt;
    logic msr_fault_r;
    logic msr_fault_nxt;

    always_comb
    begin
        msr_rdata_nxt = msr_view;
        msr_ack_nxt = i_msr_rd || i_msr_wr;
        msr_fault_nxt = (i_msr_rd && !rd_hit) || (i_msr_wr && !wr_hit);
    end

    // Model register answer registers
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            msr_rdata_r <= 64'h0000000000000000;
            msr_ack_r <= 1'b0;
            msr_fault_r <= 1'b0;
        end
        else
        begin
            msr_rdata_r <= msr_rdata_nxt;
            msr_ack_r <= msr_ack_nxt;
            msr_fault_r <= msr_fault_nxt;
        end
    end

    assign o_msr_rdata = msr_rdata_r;
    assign o_msr_ack = msr_ack_r;
    assign o_msr_fault = msr_fault_r;

    // Counter-read index window and register selection
    logic pmc_in_range;
    logic [31:0] pmc_offset;
    logic [2:0] pmc_idx;

    assign pmc_in_range = (i_pmc_index >= ucev_pkg::PMC_FIRST_INDEX) &&
                          (i_pmc_index <= ucev_pkg::PMC_LAST_INDEX);
    assign pmc_offset = i_pmc_index - ucev_pkg::PMC_FIRST_INDEX;
    assign pmc_idx = pmc_offset[2:0];

    // Low word of the selected register; zero when refused so no stale count leaks
    logic [31:0] pmc_view;

    always_comb
    begin
        pmc_view = 32'h00000000;
        if (i_pmc_rd && pmc_in_range)
        begin
            pmc_view = reg_view[pmc_idx][ucev_pkg::COUNT_MSB:ucev_pkg::COUNT_LSB];
        end
    end

    // Counter-read answer: low 32 bits, upper result forced to zero
    logic [31:0] pmc_lower_r;
    logic [31:0] pmc_lower_nxt;
    logic [31:0] pmc_upper_r;
    logic [31:0] pmc_upper_nxt;
    logic pmc_ack_r;
    logic pmc_ack_nxt;
    logic pmc_fault_r;
    logic pmc_fault_nxt;

    always_comb
    begin
        pmc_lower_nxt = pmc_view;
        pmc_upper_nxt = 32'h00000000;
        pmc_ack_nxt = i_pmc_rd;
        pmc_fault_nxt = i_pmc_rd && !pmc_in_range;
    end

    // Counter-read answer registers
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pmc_lower_r <= 32'h00000000;
            pmc_upper_r <= 32'h00000000;
            pmc_ack_r <= 1'b0;
            pmc_fault_r <= 1'b0;
        end
        else
        begin
            pmc_lower_r <= pmc_lower_nxt;
            pmc_upper_r <= pmc_upper_nxt;
            pmc_ack_r <= pmc_ack_nxt;
            pmc_fault_r <= pmc_fault_nxt;
        end
    end

    assign o_pmc_lower = pmc_lower_r;
    assign o_pmc_upper_result = pmc_upper_r;
    assign o_pmc_ack = pmc_ack_r;
    assign o_pmc_fault = pmc_fault_r;

endmodule

// ---- rtl/ucev_pkg.sv ----
// Constants for the uncore event counter block: register offsets,
// field positions, widths, reset values and counter-read indices.
// Assumes nothing; used by ucev_top, the checker and the bench.
package ucev_pkg;

    // Model register addresses of the six event registers and the two latency registers
    localparam logic [31:0] BUS_QUEUE_EVENT_0_OFS = 32'h000107cc;
    localparam logic [31:0] BUS_QUEUE_EVENT_1_OFS = 32'h000107cd;
    localparam logic [31:0] SNOOP_QUEUE_EVENT_0_OFS = 32'h000107ce;
    localparam logic [31:0] SNOOP_QUEUE_EVENT_1_OFS = 32'h000107cf;
    localparam logic [31:0] BUS_DATA_READY_EVENT_0_OFS = 32'h000107d0;
    localparam logic [31:0] BUS_DATA_READY_EVENT_1_OFS = 32'h000107d1;
    localparam logic [31:0] LATENCY_CONTROL_OFS = 32'h000107d2;
    localparam logic [31:0] LATENCY_COUNTER_OFS = 32'h000107d3;

    // Register geometry
    localparam int REG_W = 64;
    localparam int HALF_W = 32;
    localparam int NUM_EVENT_REGS = 6;
    localparam int NUM_REGS = 8;
    localparam int LATENCY_CTL_IDX = 6;
    localparam int LATENCY_CNT_IDX = 7;

    // Field positions inside a paired event register
    localparam int QUAL_LSB = 32;
    localparam int QUAL_MSB = 63;
    localparam int COUNT_LSB = 0;
    localparam int COUNT_MSB = 31;

    // Latency control enable bit
    localparam int LATENCY_EN_BIT = 26;

    // Counter-read instruction index window
    localparam logic [31:0] PMC_FIRST_INDEX = 32'h00000012;
    localparam logic [31:0] PMC_LAST_INDEX = 32'h00000019;

    // Reset values
    localparam logic [31:0] QUAL_RESET = 32'h00000000;
    localparam logic [31:0] COUNT_RESET = 32'h00000000;
    localparam logic [63:0] LATENCY_CTL_RESET = 64'h0000000000000000;
    localparam logic [63:0] LATENCY_CNT_RESET = 64'h0000000000000000;

    // Default width of the per-cycle latency weight
    localparam int LATENCY_WEIGHT_W = 8;

endpackage

// ---- rtl/ucev_count32.sv ----
// One wrapping event counter with a software load port.
// Assumes one-cycle qualified occurrence strobes on the clock.
`timescale 1ns/1ps
module ucev_count32 #(
    parameter int W = 32
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_load,
    input wire logic [W-1:0] i_load_value,
    input wire logic i_step,
    output logic [W-1:0] o_count
);

    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    // Load from software wins; otherwise step by one and wrap freely
    always_comb
    begin
        count_nxt = count_r;
        if (i_load)
        begin
            count_nxt = i_load_value;
        end
        else if (i_step)
        begin
            count_nxt = count_r + W'(1);
        end
    end

    // Counter register
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            count_r <= '0;
        else
            count_r <= count_nxt;
    end

    assign o_count = count_r;

endmodule

// ---- rtl/ucev_latency_acc.sv ----
// Weighted latency accumulator: adds a per-cycle weight while enabled.
// Assumes the weight is already the bus queue occupancy for this cycle.
`timescale 1ns/1ps
module ucev_latency_acc #(
    parameter int CW = 64,
    parameter int WW = 8
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_load,
    input wire logic [CW-1:0] i_load_value,
    input wire logic i_enable,
    input wire logic [WW-1:0] i_weight,
    output logic [CW-1:0] o_count
);

    logic [CW-1:0] acc_r;
    logic [CW-1:0] acc_nxt;

    // Load wins; while disabled the sum is frozen as it stands
    always_comb
    begin
        acc_nxt = acc_r;
        if (i_load)
        begin
            acc_nxt = i_load_value;
        end
        else if (i_enable)
        begin
            acc_nxt = acc_r + CW'(i_weight);
        end
    end

    // Accumulator register
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            acc_r <= '0;
        else
            acc_r <= acc_nxt;
    end

    assign o_count = acc_r;

endmodule

// ---- tb/ucev_props.sv ----
// Checker for the uncore event counter ports.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module ucev_props #(
    parameter int WEIGHT_W = 8
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_msr_wr,
    input wire logic i_msr_rd,
    input wire logic [31:0] i_msr_addr,
    input wire logic [63:0] i_msr_wdata,
    input wire logic [63:0] o_msr_rdata,
    input wire logic o_msr_ack,
    input wire logic o_msr_fault,
    input wire logic i_pmc_rd,
    input wire logic [31:0] i_pmc_index,
    input wire logic [31:0] o_pmc_lower,
    input wire logic [31:0] o_pmc_upper_result,
    input wire logic o_pmc_ack,
    input wire logic o_pmc_fault,
    input wire logic [1:0] i_inner_bus_request_queue_hit,
    input wire logic [1:0] i_inner_snoop_queue_hit,
    input wire logic [1:0] i_external_bus_data_ready_hit,
    input wire logic [WEIGHT_W-1:0] i_latency_weight,
    input wire logic [191:0] o_event_qual,
    input wire logic [5:0] o_event_active,
    input wire logic [63:0] o_latency_control,
    input wire logic o_latency_active
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    // Answer timing, zero upper result and refusals of both access ports
    chk_msr_ack_next: assert property ((i_msr_rd || i_msr_wr) |=> o_msr_ack)
        else $error("register access not answered");
    chk_pmc_ack_next: assert property (i_pmc_rd |=> o_pmc_ack)
        else $error("counter read not answered");
    chk_pmc_upper_zero: assert property (o_pmc_upper_result == 32'h0)
        else $error("counter read upper result not zero");
    chk_pmc_out_range: assert property (i_pmc_rd && (i_pmc_index < 32'h12 || i_pmc_index > 32'h19)
        |=> o_pmc_fault && o_pmc_lower == 32'h0)
        else $error("bad counter index not refused");
    chk_msr_unmapped: assert property ((i_msr_rd || i_msr_wr) && (i_msr_addr < ucev_pkg::BUS_QUEUE_EVENT_0_OFS
        || i_msr_addr > ucev_pkg::LATENCY_COUNTER_OFS) |=> o_msr_fault && o_msr_rdata == 64'h0)
        else $error("unmapped access not refused");

    // Qualification halves and counting enables
    chk_bus_q_start: assert property (i_msr_wr && i_msr_addr == ucev_pkg::BUS_QUEUE_EVENT_0_OFS
        |=> {o_event_qual[31:0], 32'h0} == ($past(i_msr_wdata) & 64'hffffffff_00000000)
        && o_event_active[0] == (o_event_qual[31:0] != 32'h0))
        else $error("bus queue qualifier write lost");
    chk_snoop_active: assert property (o_event_active[3:2] == {|o_event_qual[127:96], |o_event_qual[95:64]})
        else $error("snoop enable differs from qualifier");
    chk_ready_active: assert property (o_event_active[5:4] == {|o_event_qual[191:160], |o_event_qual[159:128]})
        else $error("data ready enable differs from qualifier");

    // Latency control
    chk_lat_ctl_write: assert property (i_msr_wr && i_msr_addr == ucev_pkg::LATENCY_CONTROL_OFS
        |=> o_latency_control == $past(i_msr_wdata))
        else $error("latency control write lost");
    chk_lat_bit_copy: assert property (o_latency_active == o_latency_control[26])
        else $error("latency enable differs from bit 26");

    // Main scenarios reached
    cov_pmc_fault: cover property (o_pmc_fault);
    cov_msr_fault: cover property (o_msr_fault);
    cov_lat_on: cover property (o_latency_active && i_latency_weight != '0);
endmodule

bind ucev_top ucev_props #(.WEIGHT_W(WEIGHT_W)) u_props (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_msr_wr(i_msr_wr), .i_msr_rd(i_msr_rd), .i_msr_addr(i_msr_addr), .i_msr_wdata(i_msr_wdata),
    .o_msr_rdata(o_msr_rdata), .o_msr_ack(o_msr_ack), .o_msr_fault(o_msr_fault), .i_pmc_rd(i_pmc_rd),
    .i_pmc_index(i_pmc_index), .o_pmc_lower(o_pmc_lower), .o_pmc_upper_result(o_pmc_upper_result),
    .o_pmc_ack(o_pmc_ack), .o_pmc_fault(o_pmc_fault),
    .i_inner_bus_request_queue_hit(i_inner_bus_request_queue_hit),
    .i_inner_snoop_queue_hit(i_inner_snoop_queue_hit),
    .i_external_bus_data_ready_hit(i_external_bus_data_ready_hit), .i_latency_weight(i_latency_weight),
    .o_event_qual(o_event_qual), .o_event_active(o_event_active),
    .o_latency_control(o_latency_control), .o_latency_active(o_latency_active));

// ---- tb/ucev_src_model.sv ----
// Event source model: turns bench slot requests into strobes.
// Assumes requests change just after a rising clock edge.
`timescale 1ns/1ps
module ucev_src_model #(
    parameter int WEIGHT_W = 8,
    parameter logic [7:0] WGT = 8'h05
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [6:0] i_slot,
    output logic [1:0] o_ibq_hit,
    output logic [1:0] o_isq_hit,
    output logic [1:0] o_edr_hit,
    output logic [WEIGHT_W-1:0] o_weight
);
    logic [6:0] slot_r;

    // One strobe per requested slot, a cycle later
    always_ff @(posedge i_clk or negedge i_arst_n)
        if (!i_arst_n)
            slot_r <= 7'h00;
        else
            slot_r <= i_slot;

    // Queue occupancy weight only inside a requested window
    assign o_weight = slot_r[6] ? WEIGHT_W'(WGT) : '0;
    assign o_ibq_hit = slot_r[1:0];
    assign o_isq_hit = slot_r[3:2];
    assign o_edr_hit = slot_r[5:4];
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the uncore event counters.
// Assumes the block answers every access one cycle later.
`timescale 1ns/1ps
module tb_top;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_msr_wr = 1'b0;
    logic i_msr_rd = 1'b0;
    logic [31:0] i_msr_addr = 32'h0;
    logic [63:0] i_msr_wdata = 64'h0;
    logic i_pmc_rd = 1'b0;
    logic [31:0] i_pmc_index = 32'h0;
    logic [6:0] slot = 7'h00;
    logic [1:0] ibq, isq, edr;
    logic [7:0] wgt;
    logic [63:0] o_msr_rdata;
    logic o_msr_ack, o_msr_fault, o_pmc_ack, o_pmc_fault;
    logic [31:0] o_pmc_lower, o_pmc_upper_result;
    logic [63:0] rd;
    logic flt;
    int n_mismatch = 0;
    int n_compared = 0;

    // Clock
    always #2 i_clk = ~i_clk;

    ucev_top dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_msr_wr(i_msr_wr), .i_msr_rd(i_msr_rd),
        .i_msr_addr(i_msr_addr), .i_msr_wdata(i_msr_wdata), .o_msr_rdata(o_msr_rdata), .o_msr_ack(o_msr_ack),
        .o_msr_fault(o_msr_fault), .i_pmc_rd(i_pmc_rd), .i_pmc_index(i_pmc_index), .o_pmc_lower(o_pmc_lower),
        .o_pmc_upper_result(o_pmc_upper_result), .o_pmc_ack(o_pmc_ack), .o_pmc_fault(o_pmc_fault),
        .i_inner_bus_request_queue_hit(ibq), .i_inner_snoop_queue_hit(isq),
        .i_external_bus_data_ready_hit(edr), .i_latency_weight(wgt), .o_event_qual(),
        .o_event_active(), .o_latency_control(), .o_latency_active());

    ucev_src_model src (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_slot(slot), .o_ibq_hit(ibq),
        .o_isq_hit(isq), .o_edr_hit(edr), .o_weight(wgt));

    // Compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One register access, answer taken in the cycle after the strobe
    task automatic msr(input logic wr, input logic [31:0] a, input logic [63:0] d);
        @(posedge i_clk);
        i_msr_wr <= wr;
        i_msr_rd <= !wr;
        i_msr_addr <= a;
        i_msr_wdata <= d;
        @(posedge i_clk);
        i_msr_wr <= 1'b0;
        i_msr_rd <= 1'b0;
        @(negedge i_clk);
        check(64'(o_msr_ack), 64'h1);
        rd = o_msr_rdata;
        flt = o_msr_fault;
    endtask

    // One counter read with its expected result
    task automatic pmc(input logic [31:0] idx, input logic [31:0] lo, input logic f);
        @(posedge i_clk);
        i_pmc_rd <= 1'b1;
        i_pmc_index <= idx;
        @(posedge i_clk);
        i_pmc_rd <= 1'b0;
        @(negedge i_clk);
        check({o_pmc_upper_result, o_pmc_lower}, {32'h0, lo});
        check({o_pmc_ack, o_pmc_fault}, {1'b1, f});
    endtask

    // Back-to-back strobes on one source slot, then settle
    task automatic fire(input int k, input int n);
        repeat (n)
        begin
            @(posedge i_clk);
            slot <= 7'h01 << k;
        end
        @(posedge i_clk);
        slot <= 7'h00;
        repeat (3) @(posedge i_clk);
    endtask

    task automatic t_reset();
        for (int i = 0; i < 8; i++)
        begin
            msr(1'b0, ucev_pkg::BUS_QUEUE_EVENT_0_OFS + 32'(i), 64'h0);
            check(rd, 64'h0);
        end
        $display("reset values done");
    endtask

    task automatic t_count();
        logic [31:0] q;
        for (int k = 0; k < 6; k++)
        begin
            q = 32'h80000000 >> k;
            fire(k, 2);
            msr(1'b0, ucev_pkg::BUS_QUEUE_EVENT_0_OFS + 32'(k), 64'h0);
            check(rd, 64'h0);
            msr(1'b1, ucev_pkg::BUS_QUEUE_EVENT_0_OFS + 32'(k), {q, 32'h0});
            fire(k, k + 1);
            msr(1'b0, ucev_pkg::BUS_QUEUE_EVENT_0_OFS + 32'(k), 64'h0);
            check(rd, {q, 32'(k + 1)});
            pmc(32'h12 + 32'(k), 32'(k + 1), 1'b0);
        end
        $display("event counting done");
    endtask

    task automatic t_wrap();
        msr(1'b1, ucev_pkg::BUS_QUEUE_EVENT_1_OFS, 64'h00000001_ffffffff);
        fire(1, 2);
        msr(1'b0, ucev_pkg::BUS_QUEUE_EVENT_1_OFS, 64'h0);
        check(rd, 64'h00000001_00000001);
        $display("counter wrap done");
    endtask

    task automatic t_latency();
        msr(1'b1, ucev_pkg::LATENCY_COUNTER_OFS, 64'h00000000_fffffffe);
        msr(1'b1, ucev_pkg::LATENCY_CONTROL_OFS, 64'h00000000_04000000);
        fire(6, 4);
        msr(1'b1, ucev_pkg::LATENCY_CONTROL_OFS, 64'h0);
        fire(6, 4);
        msr(1'b0, ucev_pkg::LATENCY_COUNTER_OFS, 64'h0);
        check(rd, 64'h00000001_00000012);
        pmc(32'h19, 32'h00000012, 1'b0);
        $display("latency sum done");
    endtask

    task automatic t_refuse();
        msr(1'b1, 32'h000107d4, 64'hffffffff_ffffffff);
        check(64'(flt), 64'h1);
        msr(1'b0, 32'h000107cb, 64'h0);
        check(rd, 64'h0);
        check(64'(flt), 64'h1);
        msr(1'b0, ucev_pkg::LATENCY_COUNTER_OFS, 64'h0);
        check(rd, 64'h00000001_00000012);
        check(64'(flt), 64'h0);
        pmc(32'h11, 32'h0, 1'b1);
        pmc(32'h1a, 32'h0, 1'b1);
        $display("refusals done");
    endtask

    // Final counts and verdict
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial
    begin
        repeat (5000) @(posedge i_clk);
        n_mismatch++;
        give_verdict();
    end

    // Main sequence
    initial
    begin
        repeat (4) @(posedge i_clk);
        i_arst_n <= 1'b1;
        t_reset();
        t_count();
        t_wrap();
        t_latency();
        t_refuse();
        give_verdict();
    end
endmodule
